//--- hw/tiow_defs.vh
/*
 Constants for the telegram I/O port node: timing counts and widths.
 Assumes a 100 MHz system clock.
*/
`ifndef TIOW_DEFS_VH
`define TIOW_DEFS_VH
`define TIOW_CLK_HZ 100000000
`define TIOW_WDOG_MS 100
`define TIOW_WDOG_CYCLES ((`TIOW_CLK_HZ / 1000) * `TIOW_WDOG_MS)
`define TIOW_SAMPLE_US 6800
`define TIOW_SAMPLE_CYCLES ((`TIOW_CLK_HZ / 1000000) * `TIOW_SAMPLE_US)
`define TIOW_BAUD 2500000
`define TIOW_BIT_CYCLES (`TIOW_CLK_HZ / `TIOW_BAUD)
`define TIOW_GOOD_NEEDED 2'h3
`define TIOW_PORT_W 8
`define TIOW_FAST_W 4
`endif

//--- hw/tiow_port.v
/*
 Telegram I/O port node: two 8-bit ports exchanged with telegram data bytes,
 cycle/fault/guard indicators, output watchdog, periodic input sampling.
 Assumes a telegram decoder on the same clock that marks start bit, stop bit
 and the end-of-telegram verdict (checksum, frame, write, address match)
 as one-cycle pulses; switches, jumpers and port pins are asynchronous.
*/
// Notes on behaviour
// (RULE_01) sixteen lines as two eight-bit ports
// (RULE_02) low port first byte, high second
// (RULE_03) per-line indicator shows line state
// (RULE_04) cycle indicator on start, off stop
// (RULE_05) fault indicator set on bad telegram
// (RULE_06) fault clears after three good telegrams
// (RULE_07) guard set by valid addressed write
// (RULE_08) outputs off after 100 ms silence
// (RULE_09) jumper fitted disables output watchdog
// (RULE_10) latch enabled samples inputs every 6.8 ms
// (RULE_11) one direction switch per port
// (RULE_12) switch off means input port
// (RULE_13) switch on means driven outputs
// (RULE_14) link runs 2.5 megabaud
// (RULE_15) jumpers route low bits to fast inputs
// (RULE_16) each write restarts watchdog, off until write
// (RULE_17) outputs load bytes, inputs return samples
`timescale 1ns/10ps
`include "tiow_defs.vh"
`default_nettype none

module tiow_port #(
    parameter integer WDOG_CYCLES = `TIOW_WDOG_CYCLES,
    parameter integer SAMPLE_CYCLES = `TIOW_SAMPLE_CYCLES,
    parameter integer PORT_W = `TIOW_PORT_W
) (
    input wire clk,
    input wire rst,
    input wire tel_start,
    input wire tel_stop,
    input wire tel_done,
    input wire tel_crc_ok,
    input wire tel_frame_ok,
    input wire tel_write,
    input wire tel_addr_match,
    input wire [PORT_W-1:0] tel_byte_low,
    input wire [PORT_W-1:0] tel_byte_high,
    input wire [PORT_W-1:0] pin_low_in,
    input wire [PORT_W-1:0] pin_high_in,
    input wire direction_switch_low,
    input wire direction_switch_high,
    input wire watchdog_off_jumper,
    input wire latch_on_jumper,
    input wire [`TIOW_FAST_W-1:0] fast_route_jumper,
    output reg [PORT_W-1:0] port_byte_low,
    output reg [PORT_W-1:0] port_byte_high,
    output reg port_low_oe,
    output reg port_high_oe,
    output reg [PORT_W-1:0] reply_byte_low,
    output reg [PORT_W-1:0] reply_byte_high,
    output reg [PORT_W-1:0] line_led_low,
    output reg [PORT_W-1:0] line_led_high,
    output reg cycle_indicator,
    output reg fault_indicator,
    output reg guard_indicator,
    output reg fast_irq_in_0,
    output reg fast_irq_in_1,
    output reg fast_irq_in_2,
    output reg fast_irq_in_3
);
    // counter widths follow the period parameters, so short test periods stay legal
    function integer cnt_width;
        input integer value;
        integer v;
        begin
            cnt_width = 1;
            v = value - 1;
            while (v > 1) begin
                v = v >> 1;
                cnt_width = cnt_width + 1;
            end
        end
    endfunction

    localparam integer WDOG_CW = cnt_width(WDOG_CYCLES);
    localparam integer SAMPLE_CW = cnt_width(SAMPLE_CYCLES);
    localparam integer WDOG_LOAD_I = WDOG_CYCLES - 1;
    localparam integer SAMPLE_LOAD_I = SAMPLE_CYCLES - 1;
    localparam integer ONE_I = 1;
    localparam [WDOG_CW-1:0] WDOG_LOAD = WDOG_LOAD_I[WDOG_CW-1:0];
    localparam [WDOG_CW-1:0] WDOG_STEP = ONE_I[WDOG_CW-1:0];
    localparam [WDOG_CW-1:0] WDOG_ZERO = {WDOG_CW{1'b0}};
    localparam [SAMPLE_CW-1:0] SAMPLE_LOAD = SAMPLE_LOAD_I[SAMPLE_CW-1:0];
    localparam [SAMPLE_CW-1:0] SAMPLE_STEP = ONE_I[SAMPLE_CW-1:0];
    localparam [SAMPLE_CW-1:0] SAMPLE_ZERO = {SAMPLE_CW{1'b0}};

    // three-stage synchronisers; stage 1 feeds only stage 2
    localparam integer SW = 2 * PORT_W + 4 + `TIOW_FAST_W;
    wire [SW-1:0] raw_in;
    reg [SW-1:0] sync1;
    reg [SW-1:0] sync2;
    reg [SW-1:0] sync3;
    reg [SW-1:0] stable;
    reg [SW-1:0] next_stable;
    integer k;
    assign raw_in = {fast_route_jumper, latch_on_jumper, watchdog_off_jumper,
                     direction_switch_high, direction_switch_low, pin_high_in, pin_low_in};

    always @(posedge clk) begin
        if (rst) begin
            sync1 <= {SW{1'b0}};
            sync2 <= {SW{1'b0}};
            sync3 <= {SW{1'b0}};
            stable <= {SW{1'b0}};
        end else begin
            sync1 <= raw_in;
            sync2 <= sync1;
            sync3 <= sync2;
            stable <= next_stable;
        end
    end

    // a bit moves only once stages two and three agree, so a one-cycle glitch is dropped
    always @* begin
        next_stable = stable;
        for (k = 0; k < SW; k = k + 1) begin
            if (sync2[k] == sync3[k])
                next_stable[k] = sync2[k];
        end
    end

    wire [PORT_W-1:0] in_low = stable[PORT_W-1:0];
    wire [PORT_W-1:0] in_high = stable[2*PORT_W-1:PORT_W];
    wire out_low = stable[2*PORT_W]; // RULE_11
    wire out_high = stable[2*PORT_W+1]; // RULE_11
    wire wdog_off = stable[2*PORT_W+2];
    wire latch_on = stable[2*PORT_W+3];
    wire [`TIOW_FAST_W-1:0] fast_route = stable[SW-1:2*PORT_W+4];

    wire tel_good = tel_done & tel_crc_ok & tel_frame_ok;
    wire tel_bad = tel_done & ~(tel_crc_ok & tel_frame_ok);
    wire tel_hit = tel_good & tel_write & tel_addr_match;

    // input sampling: latch mode holds samples for one period, else transparent
    // the period runs free from reset and is not aligned to telegrams
    reg [SAMPLE_CW-1:0] sample_cnt;
    reg [PORT_W-1:0] samp_low;
    reg [PORT_W-1:0] samp_high;
    wire sample_tick = (sample_cnt == SAMPLE_ZERO);

    always @(posedge clk) begin
        if (rst) begin
            sample_cnt <= SAMPLE_ZERO;
            samp_low <= {PORT_W{1'b0}};
            samp_high <= {PORT_W{1'b0}};
        end else begin
            if (sample_tick)
                sample_cnt <= SAMPLE_LOAD; // RULE_10
            else
                sample_cnt <= sample_cnt - SAMPLE_STEP;
            if (sample_tick || !latch_on) begin // RULE_10
                samp_low <= in_low;
                samp_high <= in_high;
            end
        end
    end

    // watchdog; jumper keeps outputs through timeouts
    // guard lights while the watchdog is armed and goes dark when it trips
    reg [WDOG_CW-1:0] wdog_cnt;
    reg [WDOG_CW-1:0] next_wdog_cnt;
    reg wdog_run;
    reg next_wdog_run;
    reg next_guard;
    reg [PORT_W-1:0] out_reg_low;
    reg [PORT_W-1:0] out_reg_high;
    reg [PORT_W-1:0] next_out_reg_low;
    reg [PORT_W-1:0] next_out_reg_high;
    wire wdog_expire = wdog_run && (wdog_cnt == WDOG_ZERO) && !tel_hit;

    // a hit in the expiry cycle wins, so a late but valid write never blinks the outputs
    always @* begin
        next_wdog_cnt = wdog_cnt;
        next_wdog_run = wdog_run;
        next_guard = guard_indicator;
        next_out_reg_low = out_reg_low;
        next_out_reg_high = out_reg_high;
        if (tel_hit) begin
            next_wdog_cnt = WDOG_LOAD; // RULE_16
            next_wdog_run = 1'b1;
            next_guard = 1'b1; // RULE_07
            if (out_low)
                next_out_reg_low = tel_byte_low; // RULE_17 RULE_02
            if (out_high)
                next_out_reg_high = tel_byte_high; // RULE_17 RULE_02
        end else if (wdog_expire) begin
            next_wdog_run = 1'b0;
            next_guard = 1'b0;
            if (!wdog_off) begin // RULE_09
                next_out_reg_low = {PORT_W{1'b0}}; // RULE_08 RULE_16
                next_out_reg_high = {PORT_W{1'b0}}; // RULE_08 RULE_16
            end
        end else if (wdog_run) begin
            next_wdog_cnt = wdog_cnt - WDOG_STEP;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            wdog_cnt <= WDOG_ZERO;
            wdog_run <= 1'b0;
            out_reg_low <= {PORT_W{1'b0}};
            out_reg_high <= {PORT_W{1'b0}};
            guard_indicator <= 1'b0;
        end else begin
            wdog_cnt <= next_wdog_cnt;
            wdog_run <= next_wdog_run;
            out_reg_low <= next_out_reg_low;
            out_reg_high <= next_out_reg_high;
            guard_indicator <= next_guard;
        end
    end

    // fault indicator with good-telegram streak
    // any finished telegram with clean checks counts, write or not
    reg [1:0] good_cnt;
    reg [1:0] next_good_cnt;
    reg next_fault;
    always @* begin
        next_fault = fault_indicator;
        next_good_cnt = good_cnt;
        if (tel_bad) begin
            next_fault = 1'b1; // RULE_05
            next_good_cnt = 2'h0; // RULE_06
        end else if (tel_good && fault_indicator) begin
            if (good_cnt == `TIOW_GOOD_NEEDED - 2'h1) begin
                next_fault = 1'b0; // RULE_06
                next_good_cnt = 2'h0;
            end else begin
                next_good_cnt = good_cnt + 2'h1; // RULE_06
            end
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            fault_indicator <= 1'b0;
            good_cnt <= 2'h0;
        end else begin
            fault_indicator <= next_fault;
            good_cnt <= next_good_cnt;
        end
    end

    // cycle indicator; start wins if both arrive together (RULE_14 timing is the decoder's)
    reg next_cycle;
    always @* begin
        next_cycle = cycle_indicator;
        if (tel_start)
            next_cycle = 1'b1; // RULE_04
        else if (tel_stop)
            next_cycle = 1'b0; // RULE_04
    end

    always @(posedge clk) begin
        if (rst)
            cycle_indicator <= 1'b0;
        else
            cycle_indicator <= next_cycle;
    end

    // pins, reply bytes, line leds and fast inputs
    // input ports show zero with oe low; leds track the synced pin, not the sample
    always @(posedge clk) begin
        if (rst) begin
            port_byte_low <= {PORT_W{1'b0}};
            port_byte_high <= {PORT_W{1'b0}};
            port_low_oe <= 1'b0;
            port_high_oe <= 1'b0;
            reply_byte_low <= {PORT_W{1'b0}};
            reply_byte_high <= {PORT_W{1'b0}};
            line_led_low <= {PORT_W{1'b0}};
            line_led_high <= {PORT_W{1'b0}};
            fast_irq_in_0 <= 1'b0;
            fast_irq_in_1 <= 1'b0;
            fast_irq_in_2 <= 1'b0;
            fast_irq_in_3 <= 1'b0;
        end else begin
            port_byte_low <= out_low ? out_reg_low : {PORT_W{1'b0}}; // RULE_01
            port_byte_high <= out_high ? out_reg_high : {PORT_W{1'b0}}; // RULE_01
            port_low_oe <= out_low; // RULE_13 RULE_12
            port_high_oe <= out_high; // RULE_13 RULE_12
            reply_byte_low <= out_low ? out_reg_low : samp_low; // RULE_17 RULE_02
            reply_byte_high <= out_high ? out_reg_high : samp_high; // RULE_17 RULE_02
            line_led_low <= out_low ? out_reg_low : in_low; // RULE_03
            line_led_high <= out_high ? out_reg_high : in_high; // RULE_03
            // fast inputs skip the latch so interrupts are not held back a sample period
            fast_irq_in_0 <= fast_route[0] & in_low[0]; // RULE_15
            fast_irq_in_1 <= fast_route[1] & in_low[1]; // RULE_15
            fast_irq_in_2 <= fast_route[2] & in_low[2]; // RULE_15
            fast_irq_in_3 <= fast_route[3] & in_low[3]; // RULE_15
        end
    end
endmodule // tiow_port

`default_nettype wire

//--- testbench/tiow_port_assertions.sv
/* assertions on the tiow_port ports.
   bound to every tiow_port instance. */
`timescale 1ns/10ps
`default_nettype none
module tiow_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic tel_start,
    input wire logic tel_stop,
    input wire logic tel_done,
    input wire logic tel_crc_ok,
    input wire logic tel_frame_ok,
    input wire logic tel_write,
    input wire logic tel_addr_match,
    input wire logic [7:0] tel_byte_low,
    input wire logic direction_switch_low,
    input wire logic watchdog_off_jumper,
    input wire logic [7:0] port_byte_low,
    input wire logic [7:0] port_byte_high,
    input wire logic port_low_oe,
    input wire logic cycle_indicator,
    input wire logic fault_indicator,
    input wire logic guard_indicator
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence good_wr_s;
        tel_done && tel_crc_ok && tel_frame_ok && tel_write && tel_addr_match;
    endsequence
    guard_set_a: assert property (good_wr_s |=> guard_indicator)
        else $error("guard not set");
    fault_set_a: assert property (tel_done && !(tel_crc_ok && tel_frame_ok) |=> fault_indicator)
        else $error("fault not set");
    fault_hold_a: assert property (fault_indicator && !tel_done |=> fault_indicator)
        else $error("fault cleared early");
    cycle_on_a: assert property (tel_start |=> cycle_indicator)
        else $error("cycle not on");
    cycle_off_a: assert property (tel_stop && !tel_start |=> !cycle_indicator)
        else $error("cycle not off");
    out_dir_a: assert property (direction_switch_low [*7] |-> port_low_oe)
        else $error("port not driven");
    in_port_a: assert property ((!direction_switch_low) [*7] |-> !port_low_oe && port_byte_low == 8'h00)
        else $error("input port driven");
    out_load_a: assert property (good_wr_s ##0 port_low_oe |-> ##2 port_byte_low == $past(tel_byte_low, 2))
        else $error("byte not loaded");
    wdog_off_a: assert property ($fell(guard_indicator) && !watchdog_off_jumper |=> port_byte_high == 8'h00)
        else $error("outputs kept");
    wdog_keep_a: assert property ($fell(guard_indicator) && watchdog_off_jumper |=> $stable(port_byte_high))
        else $error("outputs cleared");
endmodule // tiow_chk
bind tiow_port tiow_chk chk (.*);
`default_nettype wire

//--- testbench/tiow_ring_master.sv
/* ring master model: sends one telegram as start, stop and verdict pulses.
   caller enters send just after a rising clock edge. */
`timescale 1ns/10ps
`include "tiow_defs.vh"
`default_nettype none
module tiow_ring_master (
    input wire logic clk,
    output logic tel_start = 0,
    output logic tel_stop = 0,
    output logic tel_done = 0,
    output logic [3:0] tel_flags = 0,
    output logic [7:0] tel_lo = 0,
    output logic [7:0] tel_hi = 0
);
    task automatic send(input logic [3:0] fl, input logic [7:0] lo, input logic [7:0] hi);
        tel_start = 1;
        @(posedge clk) #1;
        tel_start = 0;
        repeat (32 * `TIOW_BIT_CYCLES - 2) @(posedge clk);
        #1;
        {tel_stop, tel_done, tel_flags, tel_lo, tel_hi} = {2'h3, fl, lo, hi};
        @(posedge clk) #1;
        // released fields show garbage, not the last verdict
        {tel_stop, tel_done, tel_flags, tel_lo, tel_hi} = {2'h0, ~fl, ~lo, ~hi};
    endtask
endmodule // tiow_ring_master
`default_nettype wire

//--- testbench/tiow_port_test.sv
/* self-checking bench for tiow_port.
   ring master model drives the telegram pulses. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; $display("BAD %0t %h %h", $time, a, b); end end
module tiow_port_test;
    logic clk = 0, rst = 1, sw_lo = 1, sw_hi = 1, wd_off = 0, latch = 1, st, sp, dn, oe_lo, oe_hi, cyc, flt, grd;
    logic [3:0] route = 4'hF, fl;
    wire [3:0] fi;
    logic [7:0] pin_lo = 8'h5A, pin_hi = 8'h00, t_l, t_h, pb_lo, pb_hi, rp_lo, rp_hi, led_lo, led_hi;
    int miscompares = 0, num_checks = 0, cyc_n = 0;
    tiow_ring_master m (.clk(clk), .tel_start(st), .tel_stop(sp), .tel_done(dn), .tel_flags(fl),
        .tel_lo(t_l), .tel_hi(t_h));
    tiow_port #(.WDOG_CYCLES(3000), .SAMPLE_CYCLES(50)) dut (.clk(clk), .rst(rst), .tel_start(st),
        .tel_stop(sp), .tel_done(dn), .tel_crc_ok(fl[3]), .tel_frame_ok(fl[2]), .tel_write(fl[1]),
        .tel_addr_match(fl[0]), .tel_byte_low(t_l), .tel_byte_high(t_h), .pin_low_in(pin_lo),
        .pin_high_in(pin_hi), .direction_switch_low(sw_lo), .direction_switch_high(sw_hi),
        .watchdog_off_jumper(wd_off), .latch_on_jumper(latch), .fast_route_jumper(route),
        .port_byte_low(pb_lo), .port_byte_high(pb_hi), .port_low_oe(oe_lo), .port_high_oe(oe_hi),
        .reply_byte_low(rp_lo), .reply_byte_high(rp_hi), .line_led_low(led_lo), .line_led_high(led_hi),
        .cycle_indicator(cyc), .fault_indicator(flt), .guard_indicator(grd), .fast_irq_in_0(fi[0]),
        .fast_irq_in_1(fi[1]), .fast_irq_in_2(fi[2]), .fast_irq_in_3(fi[3]));
    always #5 clk = ~clk;
    task print_verdict;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc_n++;
        if (cyc_n == 40000) begin
            miscompares++;
            print_verdict;
        end
    end
    task wait_n(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task t_out;
        m.send(4'hF, 8'hA5, 8'h3C);
        `CHK(grd, 1'b1)
        wait_n(2);
        `CHK({pb_lo, pb_hi, oe_lo, oe_hi}, 18'h294F3)
        `CHK({rp_lo, rp_hi, led_lo, led_hi}, 32'hA53CA53C)
        m.send(4'hE, 8'h11, 8'h22);
        wait_n(2);
        `CHK({pb_lo, pb_hi}, 16'hA53C)
    endtask
    task t_in;
        pin_lo = 8'hC6;
        sw_lo = 0;
        wait_n(60);
        `CHK({oe_lo, pb_lo}, 9'h000)
        `CHK({rp_lo, led_lo, fi}, 20'hC6C66)
        route = 4'h5;
        wait_n(8);
        `CHK(fi, 4'h4)
        latch = 0;
        pin_lo = 8'h3B;
        wait_n(8);
        `CHK({rp_lo, led_lo}, 16'h3B3B)
        pin_lo = 8'hC6;
        latch = 1;
        wait_n(8);
    endtask
    task t_wdog;
        m.send(4'hF, 8'hFF, 8'hC3);
        m.send(4'hF, 8'hFF, 8'hC3);
        wait_n(2990);
        `CHK({grd, pb_hi, rp_lo}, 17'h1C3C6)
        wait_n(20);
        `CHK({grd, pb_hi}, 9'h000)
        wd_off = 1;
        m.send(4'hF, 8'hFF, 8'h99);
        wait_n(3020);
        `CHK(pb_hi, 8'h99)
        wd_off = 0;
    endtask
    task t_fault;
        m.send(4'h4, 8'h00, 8'h00);
        `CHK(flt, 1'b1)
        repeat (2) m.send(4'hC, 8'h00, 8'h00);
        m.send(4'h8, 8'h00, 8'h00);
        `CHK(flt, 1'b1)
        repeat (2) m.send(4'hC, 8'h00, 8'h00);
        `CHK(flt, 1'b1)
        m.send(4'hC, 8'h00, 8'h00);
        `CHK(flt, 1'b0)
    endtask
    initial begin
        wait_n(10);
        `CHK({pb_lo, pb_hi, grd, flt, cyc}, 19'h0)
        rst = 0;
        wait_n(8);
        t_out;
        t_in;
        t_wdog;
        t_fault;
        print_verdict;
    end
endmodule // tiow_port_test
`default_nettype wire
